// File: include/ocie_pkg.sv
/*
 * constants, field layouts and carrier types for the oscillator control
 * interrupt-enable block. assumes a 32-bit AXI4-Lite register bus.
 */
package ocie_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_EN_CLR = 8'h00;
	localparam logic [7:0] IDX_EN_SET = 8'h04;
	localparam logic [7:0] IDX_FLAGS = 8'h08;
	localparam logic [7:0] IDX_STATUS = 8'h0C;
	localparam logic [7:0] IDX_OSC_STARTUP = 8'h16;
	localparam logic [7:0] IDX_OSC_SYNC = 8'h18;
	localparam logic [7:0] IDX_PLL_PRIMARY = 8'h1C;
	localparam logic [7:0] IDX_PLL_RATIO = 8'h20;
	localparam logic [7:0] IDX_PLL_SECONDARY = 8'h24;
	localparam logic [7:0] IDX_PLL_PRESC = 8'h28;
	localparam logic [7:0] IDX_PLL_SYNC = 8'h2C;
	localparam logic [7:0] IDX_PLL_LOCK = 8'h30;
	localparam logic [7:0] IDX_OSC_CAL = 8'h38;
	// interrupt bit positions
	localparam int BIT_CRYSTAL_READY = 0;
	localparam int BIT_CRYSTAL_FAIL = 1;
	localparam int BIT_OSC_READY = 4;
	localparam int BIT_LOCK_RISE = 8;
	localparam int BIT_LOCK_FALL = 9;
	localparam int BIT_LOCK_TIMEOUT = 10;
	localparam int BIT_RATIO_DONE = 11;
	localparam logic [31:0] IRQ_BITS = 32'h0000_0F13;
	localparam logic [31:0] IRQ_RESET = 32'h0000_0000;
	// writable field masks
	localparam logic [7:0] MASK_STARTUP = 8'h07;
	localparam logic [7:0] MASK_PRIMARY = 8'hC2;
	localparam logic [31:0] MASK_RATIO = 32'h000F_0FFF;
	localparam logic [31:0] MASK_SECONDARY = 32'hFFFF_FFFF;
	localparam logic [7:0] MASK_PRESC = 8'h03;
	localparam logic [31:0] MASK_CAL = 32'h003F_033F;
	// reset values of the configuration registers
	localparam logic [7:0] RST_STARTUP = 8'h00;
	localparam logic [7:0] RST_PRIMARY = 8'h00;
	localparam logic [31:0] RST_RATIO = 32'h0000_0000;
	localparam logic [31:0] RST_SECONDARY = 32'h0000_0000;
	localparam logic [7:0] RST_PRESC = 8'h00;
	localparam logic [31:0] RST_CAL = 32'h0000_0000;
	// pll sync-pending bits and hold time in bus cycles
	localparam int BIT_SYNC_ENABLE = 1;
	localparam int BIT_SYNC_RATIO = 2;
	localparam int BIT_SYNC_PRESC = 3;
	localparam logic [3:0] SYNC_CYCLES = 4'h4;
	localparam int BIT_LOCK = 0;
	localparam int BIT_CLK_READY = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic pll_clk_ready;
		logic pll_lock;
		logic pll_ratio_update_done;
		logic pll_lock_timeout;
		logic pll_lock_fall;
		logic pll_lock_rise;
		logic internal_osc_ready;
		logic crystal_clock_failure;
		logic crystal_ready;
	} ocie_src_s;

	typedef struct packed {
		logic [7:0] internal_osc_startup_time;
		logic [7:0] pll_control_primary;
		logic [31:0] pll_loop_ratio;
		logic [31:0] pll_control_secondary;
		logic [7:0] pll_output_prescaler;
		logic [31:0] internal_osc_calibration;
	} ocie_cfg_s;
endpackage : ocie_pkg

// File: rtl/ocie_sync.sv
/*
 * three-flop synchroniser with agreement filter and rise detection.
 * assumes inputs are asynchronous levels from the analog side.
 */
`timescale 1ns/1ps
module ocie_sync #(
	parameter int WIDTH = 9
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// change accepted only when second and third flop agree
			assign level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
	assign rise = level_next & ~level_reg;
endmodule : ocie_sync

// File: rtl/ocie_axil.sv
/*
 * AXI4-Lite slave front end: one write and one read in flight.
 * assumes the register file answers read data and error combinationally.
 */
`timescale 1ns/1ps
module ocie_axil
	import ocie_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_req,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [DATA_W-1:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_req,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic rd_err
);
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic aw_got_reg, w_got_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [DATA_W-1:0] wdata_reg, rdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_take, w_take, aw_got_next, w_got_next, bvalid_next, rvalid_next;

	assign aw_take = s_axi_awvalid & awready_reg;
	assign w_take = s_axi_wvalid & wready_reg;
	assign wr_req = aw_got_reg & w_got_reg & ~bvalid_reg;
	assign aw_got_next = (aw_got_reg | aw_take) & ~wr_req;
	assign w_got_next = (w_got_reg | w_take) & ~wr_req;
	assign bvalid_next = wr_req | (bvalid_reg & ~s_axi_bready);
	assign rd_req = s_axi_arvalid & arready_reg;
	assign rvalid_next = rd_req | (rvalid_reg & ~s_axi_rready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awready_reg <= ~aw_got_next & ~bvalid_next;
			wready_reg <= ~w_got_next & ~bvalid_next;
			bvalid_reg <= bvalid_next;
			if (wr_req) begin
				bresp_reg <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end
			if (aw_take) begin
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
			if (rd_req) begin
				rdata_reg <= rd_data;
				rresp_reg <= rd_err ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	assign wr_addr = awaddr_reg;
	assign wr_data = wdata_reg;
	assign wr_strb = wstrb_reg;
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
endmodule : ocie_axil

// File: rtl/ocie_top.sv
/*
 * oscillator control register block: interrupt enable set/clear pair,
 * sticky flags, level interrupt and oscillator/pll configuration.
 * assumes asynchronous analog status levels and an AXI4-Lite master.
 */
`timescale 1ns/1ps
module ocie_top
	import ocie_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ocie_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ocie_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ocie_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [ocie_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire ocie_pkg::ocie_src_s src_async,
	output ocie_pkg::ocie_cfg_s cfg,
	output logic irq
);
	import ocie_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == {idx[5:0], 2'b00});
	endfunction : hit

	function automatic logic [31:0] lanes(input logic [3:0] s);
		lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lanes

	function automatic logic [31:0] place(input ocie_src_s v);
		logic [31:0] w;
		w = '0;
		w[BIT_CRYSTAL_READY] = v.crystal_ready;
		w[BIT_CRYSTAL_FAIL] = v.crystal_clock_failure;
		w[BIT_OSC_READY] = v.internal_osc_ready;
		w[BIT_LOCK_RISE] = v.pll_lock_rise;
		w[BIT_LOCK_FALL] = v.pll_lock_fall;
		w[BIT_LOCK_TIMEOUT] = v.pll_lock_timeout;
		w[BIT_RATIO_DONE] = v.pll_ratio_update_done;
		place = w;
	endfunction : place

	logic wr_req, rd_req, wr_err, rd_err;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic [$bits(ocie_src_s)-1:0] lvl_raw, rise_raw;
	ocie_src_s lvl, rise;
	logic [31:0] wbits, events, status_word;
	logic [31:0] enable_reg, flags_reg, flags_next;
	logic irq_reg;
	logic [7:0] startup_reg, primary_reg, presc_reg;
	logic [31:0] ratio_reg, secondary_reg, cal_reg;
	logic [3:0] sync_busy_reg;
	logic [3:0] sync_cnt_reg;
	logic w_primary, w_ratio, w_presc;

	ocie_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_req(wr_req),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_req(rd_req),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	ocie_sync #(
		.WIDTH($bits(ocie_src_s))
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(src_async),
		.level(lvl_raw),
		.rise(rise_raw)
	);

	assign lvl = ocie_src_s'(lvl_raw);
	assign rise = ocie_src_s'(rise_raw);
	// status 0-to-1 transitions become interrupt events
	assign events = place(rise) & IRQ_BITS;
	assign status_word = place(lvl);

	// byte-lane gated write bits, reserved positions dropped
	assign wbits = wr_data & lanes(wr_strb) & IRQ_BITS;

	// shared enable state for both views
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_reg <= IRQ_RESET;
		end else if (wr_req && hit(wr_addr, IDX_EN_CLR)) begin
			enable_reg <= enable_reg & ~wbits;
		end else if (wr_req && hit(wr_addr, IDX_EN_SET)) begin
			enable_reg <= enable_reg | wbits;
		end
	end

	// sticky flags, a new event wins over a same-cycle clear
	always_comb begin
		flags_next = flags_reg;
		if (wr_req && hit(wr_addr, IDX_FLAGS)) begin
			flags_next = flags_reg & ~wbits;
		end
		flags_next = flags_next | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// one common request line
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(flags_reg & enable_reg);
		end
	end

	assign w_primary = wr_req && hit(wr_addr, IDX_PLL_PRIMARY);
	assign w_ratio = wr_req && hit(wr_addr, IDX_PLL_RATIO);
	assign w_presc = wr_req && hit(wr_addr, IDX_PLL_PRESC);

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			startup_reg <= RST_STARTUP;
			primary_reg <= RST_PRIMARY;
			ratio_reg <= RST_RATIO;
			secondary_reg <= RST_SECONDARY;
			presc_reg <= RST_PRESC;
			cal_reg <= RST_CAL;
		end else if (wr_req) begin
			if (hit(wr_addr, IDX_OSC_STARTUP) && wr_strb[0]) begin
				startup_reg <= wr_data[7:0] & MASK_STARTUP;
			end
			if (w_primary && wr_strb[0]) begin
				primary_reg <= wr_data[7:0] & MASK_PRIMARY;
			end
			if (w_ratio) begin
				ratio_reg <= ((ratio_reg & ~lanes(wr_strb)) | (wr_data & lanes(wr_strb))) & MASK_RATIO;
			end
			if (hit(wr_addr, IDX_PLL_SECONDARY)) begin
				secondary_reg <= ((secondary_reg & ~lanes(wr_strb)) | (wr_data & lanes(wr_strb))) & MASK_SECONDARY;
			end
			if (w_presc && wr_strb[0]) begin
				presc_reg <= wr_data[7:0] & MASK_PRESC;
			end
			if (hit(wr_addr, IDX_OSC_CAL)) begin
				cal_reg <= ((cal_reg & ~lanes(wr_strb)) | (wr_data & lanes(wr_strb))) & MASK_CAL;
			end
		end
	end

	// pll sync-pending: set on write, held for a fixed count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_busy_reg <= '0;
			sync_cnt_reg <= '0;
		end else if (w_primary || w_ratio || w_presc) begin
			sync_busy_reg[BIT_SYNC_ENABLE] <= sync_busy_reg[BIT_SYNC_ENABLE] | w_primary;
			sync_busy_reg[BIT_SYNC_RATIO] <= sync_busy_reg[BIT_SYNC_RATIO] | w_ratio;
			sync_busy_reg[BIT_SYNC_PRESC] <= sync_busy_reg[BIT_SYNC_PRESC] | w_presc;
			sync_cnt_reg <= SYNC_CYCLES;
		end else if (sync_cnt_reg != '0) begin
			sync_cnt_reg <= sync_cnt_reg - 4'h1;
		end else begin
			sync_busy_reg <= '0;
		end
	end

	// read decode
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		if (hit(s_axi_araddr, IDX_EN_CLR) || hit(s_axi_araddr, IDX_EN_SET)) begin
			rd_data = enable_reg & IRQ_BITS;
		end else if (hit(s_axi_araddr, IDX_FLAGS)) begin
			rd_data = flags_reg;
		end else if (hit(s_axi_araddr, IDX_STATUS)) begin
			rd_data = status_word;
		end else if (hit(s_axi_araddr, IDX_OSC_STARTUP)) begin
			rd_data = {24'h00_0000, startup_reg};
		end else if (hit(s_axi_araddr, IDX_OSC_SYNC)) begin
			rd_data = '0;
		end else if (hit(s_axi_araddr, IDX_PLL_PRIMARY)) begin
			rd_data = {24'h00_0000, primary_reg};
		end else if (hit(s_axi_araddr, IDX_PLL_RATIO)) begin
			rd_data = ratio_reg;
		end else if (hit(s_axi_araddr, IDX_PLL_SECONDARY)) begin
			rd_data = secondary_reg;
		end else if (hit(s_axi_araddr, IDX_PLL_PRESC)) begin
			rd_data = {24'h00_0000, presc_reg};
		end else if (hit(s_axi_araddr, IDX_PLL_SYNC)) begin
			rd_data = {28'h000_0000, sync_busy_reg};
		end else if (hit(s_axi_araddr, IDX_PLL_LOCK)) begin
			rd_data = '0;
			rd_data[BIT_LOCK] = lvl.pll_lock;
			rd_data[BIT_CLK_READY] = lvl.pll_clk_ready;
		end else if (hit(s_axi_araddr, IDX_OSC_CAL)) begin
			rd_data = cal_reg;
		end else begin
			rd_err = 1'b1;
		end
	end

	// writes to read-only or unmapped words answer with an error
	always_comb begin
		wr_err = 1'b1;
		if (hit(wr_addr, IDX_EN_CLR) || hit(wr_addr, IDX_EN_SET) || hit(wr_addr, IDX_FLAGS)
			|| hit(wr_addr, IDX_OSC_STARTUP) || hit(wr_addr, IDX_PLL_PRIMARY)
			|| hit(wr_addr, IDX_PLL_RATIO) || hit(wr_addr, IDX_PLL_SECONDARY)
			|| hit(wr_addr, IDX_PLL_PRESC) || hit(wr_addr, IDX_OSC_CAL)) begin
			wr_err = 1'b0;
		end
	end

	assign irq = irq_reg;
	assign cfg.internal_osc_startup_time = startup_reg;
	assign cfg.pll_control_primary = primary_reg;
	assign cfg.pll_loop_ratio = ratio_reg;
	assign cfg.pll_control_secondary = secondary_reg;
	assign cfg.pll_output_prescaler = presc_reg;
	assign cfg.internal_osc_calibration = cal_reg;
endmodule : ocie_top

// File: bench/ocie_top_asserts.sv
/*
 * concurrent checks on the enable clear/set register block ports.
 * assumes binding to ocie_top and full-word writes with address and data together.
 */
`timescale 1ns/1ps
module ocie_top_asserts
	import ocie_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ocie_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [ocie_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ocie_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [ocie_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] aw_q;
	logic [7:0] ar_q;
	logic [31:0] wd_q;
	logic [31:0] en_m;
	logic bv_q;
	always_ff @(posedge aclk) begin
		bv_q <= s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
		if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
	end
	// shadow of the enable state, one edge behind the register update
	always_ff @(posedge aclk) begin
		if (!aresetn) en_m <= 32'h0000_0000;
		else if (s_axi_bvalid && !bv_q && aw_q == 8'h00) en_m <= en_m & ~wd_q;
		else if (s_axi_bvalid && !bv_q && aw_q == 8'h10) en_m <= (en_m | wd_q) & IRQ_BITS;
	end
	property p_rst_irq; $rose(aresetn) |-> !irq; endproperty
	a_rst_irq: assert property (p_rst_irq) else $error("irq high after reset");
	property p_en_read;
		s_axi_rvalid && (ar_q == 8'h00 || ar_q == 8'h10) |-> s_axi_rdata == en_m && s_axi_rresp == RESP_OKAY;
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable readback wrong");
	property p_irq_off; (en_m == 32'h0000_0000) [*2] |-> !irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq with all disabled");
	property p_irq_fall; $fell(irq) |-> $past(s_axi_bvalid); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without a write");
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response timing");
	property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read response timing");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_busy: assert property (p_busy) else $error("write taken while busy");
	property p_unmapped; s_axi_rvalid && ar_q == 8'hFC |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
endmodule : ocie_top_asserts

// File: bench/osc_ctrl_irq_enable_clear_tb_top.sv
/*
 * self-checking bench for the enable clear/set registers and the level interrupt.
 * assumes ocie_top with one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %0t: got %h expected %h", $time, g, e); end end
module osc_ctrl_irq_enable_clear_tb_top;
	import ocie_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [31:0] rdata, en_exp, d;
	logic [1:0] bresp, rresp, resp;
	ocie_src_s src = '0;
	ocie_cfg_s cfg_o;
	int error_cnt = 0;
	int total_checks = 0;
	int irq_pos[7] = '{0, 1, 4, 8, 9, 10, 11};
	always #5 aclk = ~aclk;
	ocie_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .src_async(src), .cfg(cfg_o), .irq(irq));
	function automatic logic [31:0] f_clr(logic [31:0] en, logic [31:0] v);
		return en & ~v;
	endfunction : f_clr
	function automatic logic [31:0] f_set(logic [31:0] en, logic [31:0] v);
		return (en | v) & IRQ_BITS;
	endfunction : f_set
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	task automatic hang();
		error_cnt++;
		$display("ERROR %0t: timeout", $time);
		conclude();
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// ready early or only once the answer shows, so held responses are seen
		bready <= ($urandom_range(1) == 1);
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 50) hang();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= ($urandom_range(1) == 1);
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 50) hang();
	endtask : rd
	task automatic chk_en();
		rd(8'h00, d, resp);
		`CHK({resp, d}, {RESP_OKAY, en_exp})
		rd(8'h10, d, resp);
		`CHK({resp, d}, {RESP_OKAY, en_exp})
	endtask : chk_en
	task automatic set_en(input logic [31:0] v);
		wr(8'h10, v, resp);
		en_exp = f_set(en_exp, v);
		`CHK(resp, RESP_OKAY)
	endtask : set_en
	task automatic clr_en(input logic [31:0] v);
		wr(8'h00, v, resp);
		en_exp = f_clr(en_exp, v);
		`CHK(resp, RESP_OKAY)
	endtask : clr_en
	task automatic wait_irq(input logic v);
		int n;
		for (n = 0; n < 30; n++) begin
			@(posedge aclk);
			if (irq === v) break;
		end
		`CHK(irq, v)
	endtask : wait_irq
	initial begin
		void'($urandom(9106));
		en_exp = IRQ_RESET;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk_en();
		set_en(32'hFFFF_FFFF);
		chk_en();
		clr_en(32'h0000_0000);
		chk_en();
		clr_en(~IRQ_BITS);
		chk_en();
		foreach (irq_pos[i]) begin
			clr_en(32'h1 << irq_pos[i]);
			chk_en();
		end
		repeat (40) begin
			if ($urandom_range(1) == 1) set_en($urandom);
			else clr_en($urandom);
			chk_en();
		end
		wr(8'hFC, 32'hFFFF_FFFF, resp);
		`CHK(resp, RESP_SLVERR)
		rd(8'hFC, d, resp);
		`CHK({resp, d}, {RESP_SLVERR, 32'h0000_0000})
		clr_en(32'hFFFF_FFFF);
		chk_en();
		foreach (irq_pos[i]) begin
			src[i] <= 1'b1;
			repeat (8) @(posedge aclk);
			src[i] <= 1'b0;
			repeat (10) @(posedge aclk);
			`CHK(irq, 1'b0)
			rd(8'h20, d, resp);
			`CHK(d[irq_pos[i]], 1'b1)
			set_en(32'h1 << irq_pos[i]);
			wait_irq(1'b1);
			repeat (6) @(posedge aclk);
			`CHK(irq, 1'b1)
			clr_en(32'h1 << irq_pos[i]);
			wait_irq(1'b0);
			set_en(32'h1 << irq_pos[i]);
			wait_irq(1'b1);
			wr(8'h20, 32'h1 << irq_pos[i], resp);
			wait_irq(1'b0);
			clr_en(32'h1 << irq_pos[i]);
		end
		set_en(32'h0000_0001);
		src[0] <= 1'b1;
		wait_irq(1'b1);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		src[0] <= 1'b0;
		@(posedge aclk);
		`CHK(irq, 1'b0)
		en_exp = IRQ_RESET;
		chk_en();
		conclude();
	end
endmodule : osc_ctrl_irq_enable_clear_tb_top
bind ocie_top ocie_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
